// ---- include/obcl_defs.svh ----
`ifndef OBCL_DEFS_SVH
`define OBCL_DEFS_SVH

// Flash locations of the option bytes in the primary and the alternate bank.
`define OBCL_PRI_BASE   16'h0080
`define OBCL_ALT_BASE   16'h1080
`define OBCL_LAST_IDX   3'h4

// Byte indices inside the option area.
`define OBCL_IDX_WDOG   3'h0
`define OBCL_IDX_POC    3'h1
`define OBCL_IDX_RSV_A  3'h2
`define OBCL_IDX_RSV_B  3'h3
`define OBCL_IDX_DBG    3'h4

// Field positions of the watchdog byte.
`define OBCL_B0_RSV     7
`define OBCL_WIN_HI     6
`define OBCL_WIN_LO     5
`define OBCL_AUTO_EN    4
`define OBCL_OVF_MSB    3
`define OBCL_OVF_LSB    1
`define OBCL_LOCK       0

// Field positions of the level and debug bytes.
`define OBCL_POC_SEL    0
`define OBCL_DBG_HI     1
`define OBCL_DBG_LO     0

// Values.
`define OBCL_POC_DEFAULT 1'b0
`define OBCL_OVF_MIN     18'h00400
`define OBCL_OSC_STOP_BIT 1

// Register offsets on the plain register port.
`define OBCL_REG_STATUS  4'h0
`define OBCL_REG_OSCMODE 4'h1
`define OBCL_REG_WDOG    4'h2
`define OBCL_REG_POC     4'h3
`define OBCL_REG_DBG     4'h4
`define OBCL_OSCMODE_RST 1'b0

`endif

// ---- include/obcl_pkg.sv ----
package obcl_pkg;

   // Watchdog window open period, in order 25, 50, 75 and 100 percent.
   typedef enum logic [1:0] {
      OBCL_WIN_25,
      OBCL_WIN_50,
      OBCL_WIN_75,
      OBCL_WIN_100
   } obcl_win_t;

   // Debug access control, in the order of its two-bit field.
   typedef enum logic [1:0] {
      OBCL_DBG_OFF,
      OBCL_DBG_BAD,
      OBCL_DBG_KEEP,
      OBCL_DBG_ERASE
   } obcl_dbg_t;

   // Loader sequence.
   typedef enum logic [2:0] {
      OBCL_IDLE,
      OBCL_FETCH,
      OBCL_WAIT,
      OBCL_COPY,
      OBCL_CWAIT,
      OBCL_DONE
   } obcl_state_t;

   // Decoded settings handed to the other units.
   typedef struct packed {
      obcl_win_t  window;
      logic       auto_en;
      logic [2:0] ovf_sel;
      logic       osc_lock;
      logic       poc_level;
      obcl_dbg_t  dbg;
      logic       cfg_err;
      logic       rsv_err;
   } obcl_cfg_t;

   // Request towards the flash array.
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } obcl_flash_req_t;

endpackage

// ---- hw/obcl_cfg_decode.sv ----
`timescale 1ns/1ps
`include "obcl_defs.svh"

module obcl_cfg_decode
(
   // Clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_i,
   // Raw bytes and load strobe
   input  wire logic                 load_i,
   input  wire logic                 poc_force_i,
   input  wire logic [4:0][7:0]      bytes_i,
   // Held settings
   output obcl_pkg::obcl_cfg_t       cfg_o,
   output logic [17:0]               ovf_cycles_o,
   output logic                      valid_o
);

   typedef struct packed {
      obcl_pkg::obcl_cfg_t cfg;
      logic [17:0]         ovf;
      logic                valid;
   } obcl_dec_st_t;

   obcl_dec_st_t q;
   obcl_dec_st_t d;
   logic [7:0]   b0;

   assign b0 = bytes_i[`OBCL_IDX_WDOG];

   // Settings are taken once per reset and then held until the next one.
   always_comb
   begin
      d = q;
      if (load_i && !q.valid)
      begin
         d.valid = 1'b1;
         d.cfg.window = obcl_pkg::obcl_win_t'(b0[`OBCL_WIN_HI:`OBCL_WIN_LO]);
         d.cfg.auto_en = b0[`OBCL_AUTO_EN];
         d.cfg.ovf_sel = b0[`OBCL_OVF_MSB:`OBCL_OVF_LSB];
         d.cfg.osc_lock = b0[`OBCL_LOCK];
         d.ovf = `OBCL_OVF_MIN << b0[`OBCL_OVF_MSB:`OBCL_OVF_LSB];
         // Self-programmed level bytes cannot take effect, so the default stays.
         d.cfg.poc_level = poc_force_i ? `OBCL_POC_DEFAULT
                         : bytes_i[`OBCL_IDX_POC][`OBCL_POC_SEL];
         d.cfg.dbg = obcl_pkg::obcl_dbg_t'(
            bytes_i[`OBCL_IDX_DBG][`OBCL_DBG_HI:`OBCL_DBG_LO]);
         // Prohibited window and overflow pairing is flagged, not corrected.
         d.cfg.cfg_err = (b0[`OBCL_OVF_MSB:`OBCL_OVF_LSB] == 3'h0)
                       && (b0[`OBCL_WIN_HI:`OBCL_WIN_LO] == 2'h0);
         d.cfg.rsv_err = b0[`OBCL_B0_RSV]
                       || (bytes_i[`OBCL_IDX_POC][7:1] != 7'h00)
                       || (bytes_i[`OBCL_IDX_RSV_A] != 8'h00)
                       || (bytes_i[`OBCL_IDX_RSV_B] != 8'h00)
                       || (bytes_i[`OBCL_IDX_DBG][7:2] != 6'h00);
      end
   end

   // State register.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         q <= '0;
      else
         q <= d;
   end

   assign cfg_o        = q.cfg;
   assign ovf_cycles_o = q.ovf;
   assign valid_o      = q.valid;

endmodule

// ---- hw/obcl_clk_gate.sv ----
`timescale 1ns/1ps

module obcl_clk_gate
(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // Settings and requests
   input  wire logic valid_i,
   input  wire logic auto_en_i,
   input  wire logic lock_i,
   input  wire logic stop_req_i,
   input  wire logic halt_i,
   input  wire logic stop_i,
   // Enables
   output logic      wdog_cnt_en_o,
   output logic      timer8_en_o,
   output logic      osc_stop_o
);

   typedef struct packed {
      logic wdog_en;
      logic timer8_en;
      logic osc_stop;
   } obcl_gate_st_t;

   obcl_gate_st_t q;
   obcl_gate_st_t d;
   logic          sleeping;

   assign sleeping = halt_i || stop_i;

   // Self-programming is deliberately not an input: the watchdog keeps
   // counting through it, so late interrupts must be budgeted in software.
   always_comb
   begin
      d.osc_stop  = valid_i && stop_req_i && !lock_i;
      d.timer8_en = !d.osc_stop;
      d.wdog_en   = valid_i && auto_en_i && !d.osc_stop
                  && !(!lock_i && sleeping);
   end

   // State register.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         // Timer clock is kept from reset on, so no false gating shows after release.
         q.timer8_en <= 1'b1;
      end
      else
         q <= d;
   end

   assign wdog_cnt_en_o = q.wdog_en;
   assign timer8_en_o   = q.timer8_en;
   assign osc_stop_o    = q.osc_stop;

endmodule

// ---- hw/obcl_loader.sv ----
`timescale 1ns/1ps
`include "obcl_defs.svh"

module obcl_loader
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // Reset-time conditions
   input  wire logic        boot_swap_i,
   input  wire logic        selfprog_i,
   // Flash array
   output logic             fl_rd_o,
   output logic             fl_wr_o,
   output logic [15:0]      fl_addr_o,
   output logic [7:0]       fl_wdata_o,
   input  wire logic        fl_ack_i,
   input  wire logic [7:0]  fl_rdata_i,
   // Power modes
   input  wire logic        halt_i,
   input  wire logic        stop_i,
   // Register port
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [7:0]       reg_rdata_o,
   // Reset sequencer
   output logic             cpu_rst_hold_o,
   output logic             cfg_valid_o,
   // Watchdog
   output logic             wdog_run_o,
   output logic             ill_acc_det_en_o,
   output logic [1:0]       wdog_window_o,
   output logic [17:0]      wdog_ovf_cycles_o,
   output logic             wdog_cnt_en_o,
   // Oscillator and timer
   output logic             lowspeed_osc_stop_o,
   output logic             timer8_clk_en_o,
   // Power-on clear and debug
   output logic             poweron_clear_level_sel_o,
   output logic             dbg_en_o,
   output logic             dbg_erase_on_fail_o
);

   typedef struct packed {
      obcl_pkg::obcl_state_t     st;
      logic [2:0]                idx;
      logic [4:0][7:0]           bytes;
      logic                      swap;
      logic                      selfprog;
      obcl_pkg::obcl_flash_req_t fl;
      logic                      load;
      logic                      hold;
      logic                      stop_req;
      logic [7:0]                rdata;
      logic                      run;
      logic                      ill_det;
      logic                      dbg_en;
      logic                      dbg_erase;
   } obcl_ld_st_t;

   obcl_ld_st_t         q;
   obcl_ld_st_t         d;
   obcl_pkg::obcl_cfg_t cfg;
   logic [17:0]         ovf_cycles;
   logic                valid;
   logic [15:0]         base;
   logic [3:0]          rd_cnt_q;

   // Alternate bank base is chosen once, at the release of reset.
   // bank selection
   assign base = q.swap ? `OBCL_ALT_BASE : `OBCL_PRI_BASE;

   // Sequencer, register port and output staging in one next-state process.
   always_comb
   begin
      d = q;
      d.fl.rd = 1'b0;
      d.fl.wr = 1'b0;
      d.load = 1'b0;
      d.rdata = 8'h00;
      unique case (q.st)
         obcl_pkg::OBCL_IDLE:
         begin
            // Straps sampled by a clocked process after reset release.
            d.swap = boot_swap_i;
            d.selfprog = selfprog_i;
            d.idx = 3'h0;
            d.st = obcl_pkg::OBCL_FETCH;
         end
         obcl_pkg::OBCL_FETCH:
         begin
            d.fl.rd = 1'b1;
            d.fl.addr = base + {13'h0000, q.idx};
            d.st = obcl_pkg::OBCL_WAIT;
         end
         obcl_pkg::OBCL_WAIT:
         begin
            if (fl_ack_i)
            begin
               d.bytes[q.idx] = fl_rdata_i;
               if (q.idx == `OBCL_LAST_IDX)
               begin
                  if (q.swap)
                     d.st = obcl_pkg::OBCL_COPY;
                  else
                  begin
                     d.st = obcl_pkg::OBCL_DONE;
                     d.load = 1'b1;
                  end
               end
               else
               begin
                  d.idx = q.idx + 3'h1;
                  d.st = obcl_pkg::OBCL_FETCH;
               end
            end
         end
         obcl_pkg::OBCL_COPY:
         begin
            d.fl.wr = 1'b1;
            d.fl.addr = `OBCL_PRI_BASE + {13'h0000, `OBCL_IDX_POC};
            d.fl.wdata = q.bytes[`OBCL_IDX_POC];
            d.st = obcl_pkg::OBCL_CWAIT;
         end
         obcl_pkg::OBCL_CWAIT:
         begin
            if (fl_ack_i)
            begin
               d.st = obcl_pkg::OBCL_DONE;
               d.load = 1'b1;
            end
         end
         obcl_pkg::OBCL_DONE:
         begin
            d.st = obcl_pkg::OBCL_DONE;
         end
         default:
         begin
            d.st = obcl_pkg::OBCL_IDLE;
         end
      endcase

      d.hold = !valid;

      d.run = valid && cfg.auto_en;
      d.ill_det = valid && cfg.auto_en;

      d.dbg_en = valid && ((cfg.dbg == obcl_pkg::OBCL_DBG_KEEP)
               || (cfg.dbg == obcl_pkg::OBCL_DBG_ERASE));
      d.dbg_erase = valid && (cfg.dbg == obcl_pkg::OBCL_DBG_ERASE);

      // Stop request is the only writable bit; the lock is applied downstream.
      if (reg_wr_i && (reg_addr_i == `OBCL_REG_OSCMODE))
         d.stop_req = reg_wdata_i[`OBCL_OSC_STOP_BIT];

      // Read data stand for exactly one cycle; unmapped offsets read zero.
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            `OBCL_REG_STATUS:
               d.rdata = {4'h0, cfg.rsv_err, cfg.cfg_err, q.swap, valid};
            `OBCL_REG_OSCMODE:
               d.rdata = {6'h00, q.stop_req, 1'b0};
            `OBCL_REG_WDOG:
               d.rdata = q.bytes[`OBCL_IDX_WDOG];
            `OBCL_REG_POC:
               d.rdata = {7'h00, cfg.poc_level};
            `OBCL_REG_DBG:
               d.rdata = {6'h00, cfg.dbg};
            default:
               d.rdata = 8'h00;
         endcase
      end
   end

   // State register; the processor is held from reset onward.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.st <= obcl_pkg::OBCL_IDLE;
         q.hold <= 1'b1;
         q.stop_req <= `OBCL_OSCMODE_RST;
      end
      else
         q <= d;
   end

   // Held settings; the level bit falls back to default under self-programming with swap.
   // level decode
   obcl_cfg_decode u_decode
   (
      .sys_clk_i    (sys_clk_i),
      .rst_i        (rst_i),
      .load_i       (q.load),
      .poc_force_i  (q.swap && q.selfprog),
      .bytes_i      (q.bytes),
      .cfg_o        (cfg),
      .ovf_cycles_o (ovf_cycles),
      .valid_o      (valid)
   );

   // Count clock enables for the watchdog and the low-speed timer.
   // lock blocks stop
   obcl_clk_gate u_gate
   (
      .sys_clk_i     (sys_clk_i),
      .rst_i         (rst_i),
      .valid_i       (valid),
      .auto_en_i     (cfg.auto_en),
      .lock_i        (cfg.osc_lock),
      .stop_req_i    (q.stop_req),
      .halt_i        (halt_i),
      .stop_i        (stop_i),
      .wdog_cnt_en_o (wdog_cnt_en_o),
      .timer8_en_o   (timer8_clk_en_o),
      .osc_stop_o    (lowspeed_osc_stop_o)
   );

   // Outputs, each taken from a flip-flop.
   assign fl_rd_o                   = q.fl.rd;
   assign fl_wr_o                   = q.fl.wr;
   assign fl_addr_o                 = q.fl.addr;
   assign fl_wdata_o                = q.fl.wdata;
   assign reg_rdata_o               = q.rdata;
   assign cpu_rst_hold_o            = q.hold;
   assign cfg_valid_o               = valid;
   assign wdog_run_o                = q.run;
   assign ill_acc_det_en_o          = q.ill_det;
   assign wdog_window_o             = cfg.window;
   assign wdog_ovf_cycles_o         = ovf_cycles;
   assign poweron_clear_level_sel_o = cfg.poc_level;
   assign dbg_en_o                  = q.dbg_en;
   assign dbg_erase_on_fail_o       = q.dbg_erase;

   // Counts flash reads since reset, for the checks below only.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         rd_cnt_q <= 4'h0;
      else if (fl_rd_o)
         rd_cnt_q <= rd_cnt_q + 4'h1;
   end

   // Processor stays held until the settings are valid.
   a_hold_until_valid: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !valid |-> cpu_rst_hold_o)
      else $error("processor released before settings were valid");

   // Exactly five reads precede valid settings.
   a_five_reads_done: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(valid) |-> (rd_cnt_q == 4'h5))
      else $error("settings valid without five byte reads");

   // Every read goes to the bank chosen at reset.
   a_read_bank_sel: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      fl_rd_o |-> (fl_addr_o[12] == q.swap) && (fl_addr_o[11:3] == 9'h010))
      else $error("option read outside the selected bank");

   // The copy write only happens under swap, to the primary level byte.
   a_copy_poc_byte: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      fl_wr_o |-> q.swap && (fl_addr_o == 16'h0081)
                  && (fl_wdata_o == q.bytes[`OBCL_IDX_POC]))
      else $error("level byte copy malformed");

   // Once valid, the held settings never change.
   a_cfg_held_stable: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      valid && $past(valid) |-> $stable(cfg) && $stable(ovf_cycles))
      else $error("held settings changed after load");

   // Window output follows the two raw window bits.
   a_window_decode: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      valid |-> (wdog_window_o == q.bytes[0][6:5]))
      else $error("window period decode mismatch");

   // Watchdog start follows the auto-enable bit one cycle after valid.
   a_wdog_auto_run: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      valid |=> (wdog_run_o == q.bytes[0][4]) && (ill_acc_det_en_o == wdog_run_o))
      else $error("watchdog start does not follow auto-enable bit");

   // Overflow count is two to the power ten plus the field.
   a_ovf_cycle_count: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      valid |-> (wdog_ovf_cycles_o == (18'h00400 << q.bytes[0][3:1])))
      else $error("overflow time decode mismatch");

   // A locked oscillator is never stopped.
   a_lock_no_stop: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      lowspeed_osc_stop_o |-> !cfg.osc_lock && $past(q.stop_req))
      else $error("locked oscillator was stopped");

   // Unlocked oscillator in halt or stop withholds the watchdog clock.
   a_sleep_gates_wdog: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      valid && !cfg.osc_lock && (halt_i || stop_i) |=> !wdog_cnt_en_o)
      else $error("watchdog clocked in sleep with unlocked oscillator");

   // Timer clock follows only the oscillator, not the power mode.
   a_timer_kept_sleep: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      timer8_clk_en_o == !lowspeed_osc_stop_o)
      else $error("timer clock gated by power mode");

   // Debug enable and erase follow the two debug bits.
   a_debug_decode: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      valid |=> (dbg_en_o == q.bytes[4][1])
                && (dbg_erase_on_fail_o == (q.bytes[4][1:0] == 2'h3)))
      else $error("debug control decode mismatch");

endmodule

// ---- tb/obcl_flash_model.sv ----
`timescale 1ns/1ps

module obcl_flash_model
(
   // Clock
   input  wire logic        sys_clk_i,
   // Requests from the loader
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   // Answer
   output logic             ack_o,
   output logic [7:0]       rdata_o
);
   logic [7:0]  mem [2][5];
   int          lat;
   int          rd_count;
   logic [15:0] a;

   initial
   begin
      ack_o    = 1'b0;
      rdata_o  = 8'h00;
      lat      = 1;
      rd_count = 0;
   end

   // One request at a time; between answers the data lines toggle so a late sample is caught.
   always
   begin
      @(posedge sys_clk_i);
      if (rd_i || wr_i)
      begin
         a = addr_i;
         rd_count += int'(rd_i);
         if (wr_i && a[2:0] <= 3'h4)
            mem[a[12]][a[2:0]] = wdata_i;
         repeat (lat - 1) @(posedge sys_clk_i);
         ack_o   <= 1'b1;
         rdata_o <= (a[2:0] <= 3'h4) ? mem[a[12]][a[2:0]] : 8'hA5;
         @(posedge sys_clk_i);
         ack_o   <= 1'b0;
         rdata_o <= ~rdata_o;
      end
   end
endmodule

// ---- tb/obcl_loader_bench.sv ----
`timescale 1ns/1ps

module obcl_loader_bench;
   logic        sys_clk_i, rst_i, boot_swap_i, selfprog_i, halt_i, stop_i;
   logic        reg_wr_i, reg_rd_i, fl_rd, fl_wr, fl_ack, hold, valid, run, ill;
   logic        cnt_en, osc_stop, t8_en, poweron_clear, dbg_en, dbg_er;
   logic [3:0]  reg_addr_i;
   logic [7:0]  reg_wdata_i, reg_rdata, fl_wdata, fl_rdata, rv;
   logic [15:0] fl_addr;
   logic [1:0]  win;
   logic [17:0] ovf;
   int          fails, num_checks;

   obcl_loader dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .boot_swap_i(boot_swap_i),
      .selfprog_i(selfprog_i), .fl_rd_o(fl_rd), .fl_wr_o(fl_wr), .fl_addr_o(fl_addr),
      .fl_wdata_o(fl_wdata), .fl_ack_i(fl_ack), .fl_rdata_i(fl_rdata), .halt_i(halt_i),
      .stop_i(stop_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata),
      .cpu_rst_hold_o(hold), .cfg_valid_o(valid), .wdog_run_o(run),
      .ill_acc_det_en_o(ill), .wdog_window_o(win), .wdog_ovf_cycles_o(ovf),
      .wdog_cnt_en_o(cnt_en), .lowspeed_osc_stop_o(osc_stop), .timer8_clk_en_o(t8_en),
      .poweron_clear_level_sel_o(poweron_clear), .dbg_en_o(dbg_en), .dbg_erase_on_fail_o(dbg_er));

   obcl_flash_model flash (.sys_clk_i(sys_clk_i), .rd_i(fl_rd), .wr_i(fl_wr),
      .addr_i(fl_addr), .wdata_i(fl_wdata), .ack_o(fl_ack), .rdata_o(fl_rdata));

   // Free-running system clock at 50 MHz.
   initial
   begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("Error %s expected %0h seen %0h", nm, exp, got);
         fails++;
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Programs one bank as an external programmer would.
   task automatic set_bank(input int b, input logic [7:0] b0, b1, b4);
      // whole bank rewritten, as after a chip erase.
      flash.mem[b] = '{b0, b1, 8'h00, 8'h00, b4};
   endtask

   task automatic load(input logic sw, sp);
      int n;
      @(posedge sys_clk_i);
      boot_swap_i <= sw;
      selfprog_i  <= sp;
      rst_i       <= 1'b1;
      flash.rd_count = 0;
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      for (n = 0; n < 200; n++)
      begin
         @(posedge sys_clk_i);
         #1;
         if (valid === 1'b1)
            break;
         chk("hold_during_load", 1, hold);
      end
      chk("load_done", 1, valid);
      @(posedge sys_clk_i);
      #1;
      chk("hold_released", 0, hold);
      chk("read_count", 5, flash.rd_count);
   endtask

   task automatic chk_cfg(input logic [7:0] b0, input logic p, input logic [1:0] d);
      chk("window", b0[6:5], win);
      chk("ovf_cycles", 32'h400 << b0[3:1], ovf);
      chk("wdog_run", b0[4], run);
      chk("ill_acc", b0[4], ill);
      chk("poc_level", p, poweron_clear);
      chk("dbg_en", d[1], dbg_en);
      chk("dbg_erase", &d, dbg_er);
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Every window, overflow and debug code, with varying flash latency.
   task automatic t_decode();
      logic [7:0] b0;
      for (int i = 0; i < 8; i++)
      begin
         // window and overflow fields are never both zero.
         b0 = {1'b0, i[1:0], i[0], 3'(7 - i), i[1]};
         flash.lat = 1 + i % 3;
         set_bank(0, b0, {7'h00, i[2]}, {6'h00, i[1:0]});
         load(1'b0, 1'b0);
         chk_cfg(b0, i[2], i[1:0]);
      end
      flash.lat = 1;
   endtask

   // Swap reads the alternate bank and copies its level byte to the primary one.
   task automatic t_swap();
      set_bank(0, 8'h30, 8'h00, 8'h00);
      set_bank(1, 8'h5B, 8'h01, 8'h03);
      load(1'b1, 1'b0);
      chk_cfg(8'h5B, 1'b1, 2'h3);
      chk("level_copy", 8'h01, flash.mem[0][1]);
      reg_read(4'h0, rv);
      chk("status", 8'h03, rv);
      set_bank(0, 8'h30, 8'h00, 8'h00);
      load(1'b1, 1'b1);
      chk("poc_selfprog", 0, poweron_clear);
      chk("run_selfprog", 1, run);
   endtask

   // Software stop request, lock bit and power-mode gating.
   task automatic t_osc();
      set_bank(0, 8'h30, 8'h00, 8'h00);
      load(1'b0, 1'b0);
      reg_read(4'hF, rv);
      chk("unmapped", 8'h00, rv);
      reg_write(4'h2, 8'hFF);
      reg_read(4'h2, rv);
      chk("raw_byte_held", 8'h30, rv);
      @(posedge sys_clk_i);
      halt_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("cnt_halt", 0, cnt_en);
      chk("t8_halt", 1, t8_en);
      @(posedge sys_clk_i);
      halt_i <= 1'b0;
      stop_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("cnt_stop", 0, cnt_en);
      @(posedge sys_clk_i);
      stop_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("cnt_run", 1, cnt_en);
      reg_write(4'h1, 8'h02);
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("osc_stop", 1, osc_stop);
      chk("t8_stopped", 0, t8_en);
      reg_read(4'h1, rv);
      chk("oscmode", 8'h02, rv);
      set_bank(0, 8'h31, 8'h00, 8'h00);
      load(1'b0, 1'b0);
      reg_write(4'h1, 8'h02);
      halt_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("osc_locked", 0, osc_stop);
      chk("cnt_locked_halt", 1, cnt_en);
      @(posedge sys_clk_i);
      halt_i <= 1'b0;
      // Out-of-rule bytes are only flagged; status must show both flags.
      set_bank(0, 8'h80, 8'h02, 8'h00);
      load(1'b0, 1'b0);
      reg_read(4'h0, rv);
      chk("status_flags", 8'h0D, rv);
   endtask

   // Guards against a hang in any wait.
   initial
   begin
      #400000;
      fails++;
      report_and_stop();
   end

   initial
   begin
      fails = 0;
      num_checks = 0;
      rst_i = 1'b1;
      boot_swap_i = 1'b0;
      selfprog_i = 1'b0;
      halt_i = 1'b0;
      stop_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 4'h0;
      reg_wdata_i = 8'h00;
      t_decode();
      t_swap();
      t_osc();
      report_and_stop();
   end
endmodule
